// ===== rtl/dmacmd_regs.sv
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module dmacmd_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic [31:0] hwReqIn,
  input wire logic [15:0] irqSet,
  input wire logic [15:0] errSet,
  input wire logic [15:0] startClr,
  input wire logic [15:0] doneSet,
  input wire logic [31:0] reqDisable,
  output logic [31:0] reqEnableOut,
  output logic [31:0] hwReqAccepted,
  output logic [15:0] irqOut,
  output logic [15:0] errIrqOut,
  output logic groupErrIrq,
  output logic [15:0] startOut,
  output logic [15:0] doneOut
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [31:0] reqEn_q;
  logic [15:0] errEn_q;
  logic [15:0] irq_q;
  logic [15:0] err_q;
  logic [15:0] start_q;
  logic [15:0] done_q;
  logic [31:0] hwReqS1_q;
  logic [31:0] hwReqS2_q;
  logic [31:0] regRdData_q;
  logic [31:0] hwReqAcc_q;
  logic [15:0] errIrq_q;
  logic groupErr_q;

  // ---------------------------------------------------------------------------
  // timing summary
  // ---------------------------------------------------------------------------
  // every command lands at the edge that samples the write strobe
  // read data stand for the single cycle after the read strobe
  // error interrupt outputs trail the flags by one cycle
  // because they are registered; software polling the flags sees
  // them first, which is harmless since the outputs only ever lag
  // hardware requests pass two sync flops and one gating flop,
  // so an accepted request trails its pin by three edges
  // the clock enable freezes every flop, the read data included,
  // so a host that stalls the block sees no state move at all

  // ---------------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------------
  logic wrWord0;
  logic wrWord1;
  assign wrWord0 = regWrite && (regAddr == dmacmd_pkg::ADDR_CMD_WORD0);
  assign wrWord1 = regWrite && (regAddr == dmacmd_pkg::ADDR_CMD_WORD1);

  // one-hot / all mask from one command byte; reserved values act as no-op
  function automatic logic [31:0] cmdMask(input logic [7:0] b, input logic [6:0] limit);
    logic [31:0] m;
    m = dmacmd_pkg::ZERO_WORD;
    if (!b[dmacmd_pkg::SKIP_BIT]) begin
      if (b[dmacmd_pkg::GLOBAL_BIT]) begin
        m = ~dmacmd_pkg::ZERO_WORD;
      end else if (b[6:0] < limit) begin
        m[b[4:0]] = 1'b1;
      end
    end
    return m;
  endfunction

  // ---------------------------------------------------------------------------
  // command lanes
  // ---------------------------------------------------------------------------
  logic [7:0] laneReqSet;
  logic [7:0] laneReqClr;
  logic [7:0] laneEenSet;
  logic [7:0] laneEenClr;
  logic [7:0] laneDoneClr;
  logic [7:0] laneStartSet;
  logic [7:0] laneErrClr;
  logic [7:0] laneIrqClr;
  // bytes pulled out by name so the decode below reads plainly
  assign laneReqSet = regWrData[8*dmacmd_pkg::LANE_REQ_SET +: 8];
  assign laneReqClr = regWrData[8*dmacmd_pkg::LANE_REQ_CLR +: 8];
  assign laneEenSet = regWrData[8*dmacmd_pkg::LANE_EEN_SET +: 8];
  assign laneEenClr = regWrData[8*dmacmd_pkg::LANE_EEN_CLR +: 8];
  assign laneDoneClr = regWrData[8*dmacmd_pkg::LANE_DONE_CLR +: 8];
  assign laneStartSet = regWrData[8*dmacmd_pkg::LANE_START_SET +: 8];
  assign laneErrClr = regWrData[8*dmacmd_pkg::LANE_ERR_CLR +: 8];
  assign laneIrqClr = regWrData[8*dmacmd_pkg::LANE_IRQ_CLR +: 8];

  // ---------------------------------------------------------------------------
  // command masks
  // ---------------------------------------------------------------------------
  logic [31:0] reqSetM, reqClrM;
  logic [15:0] eenSetM, eenClrM, irqClrM, errClrM, startSetM, doneClrM;
  // each lane decoded independently so one word runs all its commands
  // the 32-bit mask is cut to sixteen bits on purpose for channel maps
  always_comb begin
    reqSetM = wrWord0 ? cmdMask(laneReqSet, dmacmd_pkg::RANGE_REQ_LIMIT) : dmacmd_pkg::ZERO_WORD;
    reqClrM = wrWord0 ? cmdMask(laneReqClr, dmacmd_pkg::RANGE_REQ_LIMIT) : dmacmd_pkg::ZERO_WORD;
    eenSetM = wrWord0 ? 16'(cmdMask(laneEenSet, dmacmd_pkg::RANGE_CH_LIMIT)) : 16'h0000;
    eenClrM = wrWord0 ? 16'(cmdMask(laneEenClr, dmacmd_pkg::RANGE_CH_LIMIT)) : 16'h0000;
    doneClrM = wrWord1 ? 16'(cmdMask(laneDoneClr, dmacmd_pkg::RANGE_CH_LIMIT)) : 16'h0000;
    startSetM = wrWord1 ? 16'(cmdMask(laneStartSet, dmacmd_pkg::RANGE_CH_LIMIT)) : 16'h0000;
    errClrM = wrWord1 ? 16'(cmdMask(laneErrClr, dmacmd_pkg::RANGE_CH_LIMIT)) : 16'h0000;
    irqClrM = wrWord1 ? 16'(cmdMask(laneIrqClr, dmacmd_pkg::RANGE_CH_LIMIT)) : 16'h0000;
  end

  logic wrReqMap, wrEenMap, wrIrqMap, wrErrMap;
  assign wrReqMap = regWrite && (regAddr == dmacmd_pkg::ADDR_REQ_EN_MAP);
  assign wrEenMap = regWrite && (regAddr == dmacmd_pkg::ADDR_ERR_EN_MAP);
  assign wrIrqMap = regWrite && (regAddr == dmacmd_pkg::ADDR_IRQ_MAP);
  assign wrErrMap = regWrite && (regAddr == dmacmd_pkg::ADDR_ERR_MAP);

  // write-one-to-clear views of the direct flag map writes
  logic [15:0] irqMapClr;
  logic [15:0] errMapClr;
  assign irqMapClr = wrIrqMap ? regWrData[15:0] : 16'h0000;
  assign errMapClr = wrErrMap ? regWrData[15:0] : 16'h0000;

  // ---------------------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------------------
  logic [31:0] reqEn_d;
  logic [15:0] errEn_d;
  logic [15:0] irq_d;
  logic [15:0] err_d;
  logic [15:0] start_d;
  logic [15:0] done_d;

  // request enables: map write beats commands, set beats clear
  // the engine's end-of-loop disable is a clear, so a set still wins
  always_comb begin
    if (wrReqMap) begin
      reqEn_d = regWrData;
    end else begin
      reqEn_d = (reqEn_q & ~reqClrM & ~reqDisable) | reqSetM;
    end
  end

  // error-interrupt enables: only the low sixteen bits exist
  always_comb begin
    if (wrEenMap) begin
      errEn_d = regWrData[15:0];
    end else begin
      errEn_d = (errEn_q & ~eenClrM) | eenSetM;
    end
  end

  // flags: a hardware set in the clearing cycle wins, so no event is lost
  always_comb begin
    irq_d = (irq_q & ~irqClrM & ~irqMapClr) | irqSet;
    err_d = (err_q & ~errClrM & ~errMapClr) | errSet;
    start_d = (start_q & ~startClr) | startSetM;
    done_d = (done_q & ~doneClrM) | doneSet;
  end

  // ---------------------------------------------------------------------------
  // request enables
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reqEn_q <= dmacmd_pkg::ZERO_WORD;
    end else if (clkEn) begin
      reqEn_q <= reqEn_d;
    end
  end

  // ---------------------------------------------------------------------------
  // error-interrupt enables
  // ---------------------------------------------------------------------------
  // reset to zero so no error interrupt fires before software asks
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      errEn_q <= dmacmd_pkg::EEN_RESET;
    end else if (clkEn) begin
      errEn_q <= errEn_d;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt and error flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_q <= 16'h0000;
      err_q <= 16'h0000;
    end else if (clkEn) begin
      irq_q <= irq_d;
      err_q <= err_d;
    end
  end

  // ---------------------------------------------------------------------------
  // start and done bits
  // ---------------------------------------------------------------------------
  // these mirror descriptor bits; the engine owns the other direction
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_q <= 16'h0000;
      done_q <= 16'h0000;
    end else if (clkEn) begin
      start_q <= start_d;
      done_q <= done_d;
    end
  end

  // ---------------------------------------------------------------------------
  // request pins: two-flop synchroniser, then gate with the enable
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hwReqS1_q <= dmacmd_pkg::ZERO_WORD;
      hwReqS2_q <= dmacmd_pkg::ZERO_WORD;
      hwReqAcc_q <= dmacmd_pkg::ZERO_WORD;
    end else if (clkEn) begin
      hwReqS1_q <= hwReqIn;
      hwReqS2_q <= hwReqS1_q;
      hwReqAcc_q <= hwReqS2_q & reqEn_q;
    end
  end

  // ---------------------------------------------------------------------------
  // error interrupts, registered so outputs come from flops
  // ---------------------------------------------------------------------------
  logic [15:0] errTerm;
  // one gated term per channel; costs a cycle of lag, keeps outputs glitch free
  for (genvar ch = 0; ch < dmacmd_pkg::NUM_CH; ch++) begin : g_errTerm
    assign errTerm[ch] = err_q[ch] & errEn_q[ch];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      errIrq_q <= 16'h0000;
      groupErr_q <= 1'b0;
    end else if (clkEn) begin
      errIrq_q <= errTerm;
      groupErr_q <= |errTerm;
    end
  end

  // ---------------------------------------------------------------------------
  // read port: data one cycle after the strobe, unmapped reads zero
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regRdData_q <= dmacmd_pkg::ZERO_WORD;
    end else if (clkEn) begin
      regRdData_q <= dmacmd_pkg::ZERO_WORD;
      if (regRead) begin
        unique case (regAddr)
          dmacmd_pkg::ADDR_REQ_EN_MAP: regRdData_q <= reqEn_q;
          dmacmd_pkg::ADDR_ERR_EN_MAP: regRdData_q <= {16'h0000, errEn_q};
          dmacmd_pkg::ADDR_IRQ_MAP: regRdData_q <= {16'h0000, irq_q};
          dmacmd_pkg::ADDR_ERR_MAP: regRdData_q <= {16'h0000, err_q};
          dmacmd_pkg::ADDR_START_MAP: regRdData_q <= {16'h0000, start_q};
          dmacmd_pkg::ADDR_DONE_MAP: regRdData_q <= {16'h0000, done_q};
          default: regRdData_q <= dmacmd_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  assign regRdData = regRdData_q;
  assign reqEnableOut = reqEn_q;
  assign hwReqAccepted = hwReqAcc_q;
  assign irqOut = irq_q;
  assign errIrqOut = errIrq_q;
  assign groupErrIrq = groupErr_q;
  assign startOut = start_q;
  assign doneOut = done_q;

endmodule

// ===== rtl/dmacmd_pkg.sv
package dmacmd_pkg;

  // ---------------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int REQ_CH = 32;
  localparam int ADDR_W = 8;
  localparam int CH_W = 5;

  // ---------------------------------------------------------------------------
  // register word addresses (byte addresses, word aligned)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_REQ_EN_MAP = 8'h0C;
  localparam logic [7:0] ADDR_ERR_EN_MAP = 8'h14;
  localparam logic [7:0] ADDR_CMD_WORD0 = 8'h18;
  localparam logic [7:0] ADDR_CMD_WORD1 = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MAP = 8'h24;
  localparam logic [7:0] ADDR_ERR_MAP = 8'h2C;
  localparam logic [7:0] ADDR_START_MAP = 8'h30;
  localparam logic [7:0] ADDR_DONE_MAP = 8'h34;

  // ---------------------------------------------------------------------------
  // command byte lanes: word0 = {errEnClr, errEnSet, reqClr, reqSet}
  // word1 = {irqClr, errClr, startSet, doneClr}
  // ---------------------------------------------------------------------------
  localparam int LANE_REQ_SET = 0;
  localparam int LANE_REQ_CLR = 1;
  localparam int LANE_EEN_SET = 2;
  localparam int LANE_EEN_CLR = 3;
  localparam int LANE_DONE_CLR = 0;
  localparam int LANE_START_SET = 1;
  localparam int LANE_ERR_CLR = 2;
  localparam int LANE_IRQ_CLR = 3;

  // ---------------------------------------------------------------------------
  // command byte fields
  // ---------------------------------------------------------------------------
  localparam int SKIP_BIT = 7;
  localparam int GLOBAL_BIT = 6;
  localparam logic [6:0] RANGE_REQ_LIMIT = 7'h20;
  localparam logic [6:0] RANGE_CH_LIMIT = 7'h10;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] EEN_RESET = 16'h0000;

endpackage

// ===== tb/dmacmd_checker.sv
`timescale 1ns/1ps
module dmacmd_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic [31:0] reqDisable,
  input wire logic [15:0] startClr,
  input wire logic [31:0] reqEnableOut,
  input wire logic [31:0] hwReqAccepted,
  input wire logic [15:0] errIrqOut,
  input wire logic groupErrIrq,
  input wire logic [15:0] startOut
);
  // ---------------------------------------------------------------------------
  // command word decode
  // ---------------------------------------------------------------------------
  logic wr0;
  logic wr1;
  // decoded once so each property stays short
  assign wr0 = regWrite && clkEn && regAddr == dmacmd_pkg::ADDR_CMD_WORD0;
  assign wr1 = regWrite && clkEn && regAddr == dmacmd_pkg::ADDR_CMD_WORD1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_rdIdle;
    $past(clkEn) && !$past(regRead) |-> regRdData == dmacmd_pkg::ZERO_WORD;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not zero outside read slot");
  property p_cmdRd;
    regRead && clkEn && (regAddr == dmacmd_pkg::ADDR_CMD_WORD0 || regAddr == dmacmd_pkg::ADDR_CMD_WORD1)
      |=> regRdData == dmacmd_pkg::ZERO_WORD;
  endproperty
  a_cmdRd: assert property (p_cmdRd) else $error("command word read not zero");
  property p_group;
    groupErrIrq == (|errIrqOut);
  endproperty
  a_group: assert property (p_group) else $error("group error irq mismatch");
  property p_hwReq;
    (hwReqAccepted & ~$past(reqEnableOut)) == dmacmd_pkg::ZERO_WORD;
  endproperty
  a_hwReq: assert property (p_hwReq) else $error("request accepted while disabled");
  property p_reqSet1;
    wr0 && regWrData[7:5] == 3'b000 && reqDisable == 32'h0000_0000 |=> reqEnableOut[$past(regWrData[4:0])];
  endproperty
  a_reqSet1: assert property (p_reqSet1) else $error("single request set missing");
  property p_reqSetAll;
    wr0 && regWrData[7:6] == 2'b01 && reqDisable == 32'h0000_0000 |=> reqEnableOut == 32'hFFFF_FFFF;
  endproperty
  a_reqSetAll: assert property (p_reqSetAll) else $error("global request set missing");
  property p_reqClrAll;
    wr0 && regWrData[7] && regWrData[15:14] == 2'b01 |=> reqEnableOut == 32'h0000_0000;
  endproperty
  a_reqClrAll: assert property (p_reqClrAll) else $error("global request clear missing");
  // flags feed errIrqOut one cycle late, so the check waits a quiet cycle
  property p_eenClrAll;
    wr0 && regWrData[31:30] == 2'b01 && regWrData[23] ##1 (clkEn && !regWrite) |=> errIrqOut == 16'h0000;
  endproperty
  a_eenClrAll: assert property (p_eenClrAll) else $error("error irq after enables cleared");
  property p_startAll;
    wr1 && regWrData[15:14] == 2'b01 && startClr == 16'h0000 |=> startOut == 16'hFFFF;
  endproperty
  a_startAll: assert property (p_startAll) else $error("global start set missing");
endmodule

bind dmacmd_regs dmacmd_checker dmacmd_checker_inst (.clk, .reset_n, .clkEn, .regAddr, .regWrData,
  .regWrite, .regRead, .regRdData, .reqDisable, .startClr, .reqEnableOut, .hwReqAccepted, .errIrqOut,
  .groupErrIrq, .startOut);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] W0 = dmacmd_pkg::ADDR_CMD_WORD0;
  localparam logic [7:0] W1 = dmacmd_pkg::ADDR_CMD_WORD1;
  localparam logic [7:0] EEN = dmacmd_pkg::ADDR_ERR_EN_MAP;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000, hwReqIn = 32'h0000_0000, reqDisable = 32'h0000_0000;
  logic [15:0] irqSet = 16'h0000, errSet = 16'h0000, startClr = 16'h0000, doneSet = 16'h0000;
  logic [31:0] regRdData, reqEnableOut, hwReqAccepted;
  logic [15:0] irqOut, errIrqOut, startOut, doneOut;
  logic groupErrIrq;
  int errTotal = 0;
  int checkCount = 0;
  int cycles = 0;
  // ---------------------------------------------------------------------------
  // clock, device, hang guard
  // ---------------------------------------------------------------------------
  always #20 clk = ~clk;
  dmacmd_regs dmacmd_regs_inst (.clk, .reset_n, .clkEn, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .hwReqIn, .irqSet, .errSet, .startClr, .doneSet, .reqDisable, .reqEnableOut,
    .hwReqAccepted, .irqOut, .errIrqOut, .groupErrIrq, .startOut, .doneOut);
  // run needs under a hundred cycles; far above that means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errTotal++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ends mid-cycle so results of the write edge have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regRdData, exp);
  endtask
  task automatic report_and_stop();
    if (errTotal == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_resetVals();
    rdChk(EEN, 32'h0000_0000);
    rdChk(W0, 32'h0000_0000);
    rdChk(8'hFC, 32'h0000_0000);
  endtask
  task automatic t_reqCmds();
    wr(W0, 32'h8080_801F);
    chk(reqEnableOut, 32'h8000_0000);
    wr(W0, 32'h8080_8080);
    chk(reqEnableOut, 32'h8000_0000);
    wr(W0, 32'h8080_80FF);
    chk(reqEnableOut, 32'h8000_0000);
    wr(W0, 32'h8080_8040);
    chk(reqEnableOut, 32'hFFFF_FFFF);
    wr(W0, 32'h8080_0580);
    chk(reqEnableOut, 32'hFFFF_FFDF);
    wr(W0, 32'h8080_7F80);
    chk(reqEnableOut, 32'h0000_0000);
    wr(W0, 32'h8080_0302);
    chk(reqEnableOut, 32'h0000_0004);
    rdChk(W1, 32'h0000_0000);
    @(posedge clk);
    hwReqIn <= 32'hFFFF_FFFF;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk(hwReqAccepted, 32'h0000_0004);
    hwReqIn <= 32'h0000_0000;
  endtask
  task automatic t_errEn();
    wr(EEN, 32'hFFFF_FFFF);
    rdChk(EEN, 32'h0000_FFFF);
    wr(W0, 32'h4080_8080);
    rdChk(EEN, 32'h0000_0000);
    wr(W0, 32'h800F_8080);
    rdChk(EEN, 32'h0000_8000);
    wr(W0, 32'h8040_8080);
    wr(W0, 32'h0080_8080);
    rdChk(EEN, 32'h0000_FFFE);
    @(posedge clk);
    errSet <= 16'h0003;
    @(posedge clk);
    errSet <= 16'h0000;
    repeat (2) @(negedge clk);
    chk({16'h0000, errIrqOut}, 32'h0000_0002);
    chk({31'h0, groupErrIrq}, 32'h0000_0001);
    wr(W1, 32'h8001_8080);
    @(negedge clk);
    chk({16'h0000, errIrqOut}, 32'h0000_0000);
    chk({31'h0, groupErrIrq}, 32'h0000_0000);
  endtask
  task automatic t_word1();
    @(posedge clk);
    irqSet <= 16'hFFFF;
    doneSet <= 16'hFFFF;
    @(posedge clk);
    irqSet <= 16'h0000;
    doneSet <= 16'h0000;
    wr(W1, 32'h0280_0340);
    chk({irqOut, startOut}, 32'hFFFB_0008);
    chk({16'h0000, doneOut}, 32'h0000_0000);
    @(posedge clk);
    doneSet <= 16'hFFFF;
    @(posedge clk);
    doneSet <= 16'h0000;
    wr(W1, 32'h4080_4004);
    chk({irqOut, startOut}, 32'h0000_FFFF);
    chk({16'h0000, doneOut}, 32'h0000_FFEF);
  endtask
  // direct map writes, engine inputs and a frozen clock enable
  task automatic t_mapsEngine();
    wr(dmacmd_pkg::ADDR_REQ_EN_MAP, 32'h0000_00F0);
    chk(reqEnableOut, 32'h0000_00F0);
    @(posedge clk);
    reqDisable <= 32'h0000_0010;
    @(posedge clk);
    reqDisable <= 32'h0000_0000;
    @(negedge clk);
    chk(reqEnableOut, 32'h0000_00E0);
    @(posedge clk);
    clkEn <= 1'b0;
    wr(W0, 32'h8080_8040);
    clkEn <= 1'b1;
    chk(reqEnableOut, 32'h0000_00E0);
    @(posedge clk);
    irqSet <= 16'h0011;
    startClr <= 16'h0001;
    @(posedge clk);
    irqSet <= 16'h0000;
    startClr <= 16'h0000;
    wr(dmacmd_pkg::ADDR_IRQ_MAP, 32'h0000_0001);
    chk({16'h0000, irqOut}, 32'h0000_0010);
    chk({16'h0000, startOut}, 32'h0000_FFFE);
  endtask
  // main sequence: reset for twelve cycles, then every scenario
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_resetVals();
    t_reqCmds();
    t_errEn();
    t_word1();
    t_mapsEngine();
    report_and_stop();
  end
endmodule
